// ---- verilog/cal_cfg_pkg.sv ----
// Package for the channel calibration and configuration register bank.
// Assumes a classic Wishbone slave with 32-bit data, one word per register.
package cal_cfg_pkg;

   // ************************************************************
   // Register indices and byte addresses (address = 4 * index)
   // ************************************************************
   localparam logic [7:0] IDX_CH5_GAIN_CAL_HIGH   = 8'h25;
   localparam logic [7:0] IDX_CH5_GAIN_CAL_LOW    = 8'h26;
   localparam logic [7:0] IDX_CH6_CONFIG          = 8'h27;
   localparam logic [7:0] IDX_CH6_OFFSET_CAL_HIGH = 8'h28;
   localparam logic [7:0] IDX_CH6_OFFSET_CAL_LOW  = 8'h29;
   localparam logic [7:0] IDX_CH6_GAIN_CAL_HIGH   = 8'h2A;
   localparam int         ADDR_W                  = 10;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [15:0] RST_GAIN_HIGH   = 16'h8000;
   localparam logic [15:0] RST_GAIN_LOW    = 16'h0000;
   localparam logic [15:0] RST_OFFSET_HIGH = 16'h0000;
   localparam logic [15:0] RST_OFFSET_LOW  = 16'h0000;
   localparam logic [15:0] RST_CONFIG      = 16'h0000;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int LOW_FIELD_LSB   = 8;   // Low word data in [15:8]
   localparam int PHASE_LSB       = 6;   // Phase delay in [15:6]
   localparam int DC_OFF_BIT      = 2;
   localparam int INPUT_SEL_LSB   = 0;   // Input select in [1:0]
   localparam logic [15:0] LOW_WRITE_MASK    = 16'hFF00;
   localparam logic [15:0] CONFIG_WRITE_MASK = 16'hFFC7;

   // Input selector encodings
   typedef enum logic [1:0] {
      INPUT_NORMAL   = 2'h0,
      INPUT_SHORTED  = 2'h1,
      INPUT_TEST_POS = 2'h2,
      INPUT_TEST_NEG = 2'h3
   } input_select_type;

   // Channel 6 configuration as seen by the converter datapath
   typedef struct packed {
      logic signed [9:0] phase_delay;
      logic              dc_filter_off;
      input_select_type  input_select;
   } ch_config_type;

   // Wishbone request carrier
   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [3:0]        sel;
      logic [ADDR_W-1:0] adr;
      logic [31:0]       dat;
   } wb_req_type;

endpackage : cal_cfg_pkg

// ---- verilog/cal_cfg_regs.sv ----
// Register bank for channel 5 gain and channel 6 config/offset/gain.
// Assumes a classic Wishbone master on sys_clk_i; reads/writes answer in
// one wait state, ack high for exactly one cycle per request.
// Assumes the converter datapath samples the 24-bit words as plain levels
// and tolerates the one-cycle lag behind the stored registers.
`timescale 1ns/100ps

// Function
// - Gain word is 24 bits: high register bits 23:8, low [15:8] bits 7:0.
// - Gain word is unsigned, codes mapping linearly from 0 to under 2.0.
// - Reset loads gain high with 8000h and gain low with zero.
// - Low register bits 7:0 ignore writes and read zero.
// - Config bits 15:6 hold signed 10-bit phase delay, reset zero.
// - Config bits 5:3 are read-only zero.
// - Config bit 2 set disables DC filter; clear defers to global setting.
// - Config bits 1:0 select normal, shorted, positive or negative test.
// - Offset word is 24-bit two's complement from high and low registers.
// - Reset clears offset registers and channel configuration register.
module cal_cfg_regs (
   input  wire logic                       sys_clk_i,
   input  wire logic                       arst_n_i,
   input  wire cal_cfg_pkg::wb_req_type    wb_req_i,
   input  wire logic                       global_dc_filter_setting_i,
   output logic [31:0]                     wb_dat_o,
   output logic                            wb_ack_o,
   output logic [23:0]                     ch5_gain_o,
   output logic [23:0]                     ch6_gain_high_o,
   output logic signed [23:0]              ch6_offset_o,
   output cal_cfg_pkg::ch_config_type      ch6_config_o,
   output logic                            ch6_dc_filter_on_o
);
   import cal_cfg_pkg::*;

   // ************************************************************
   // Storage
   // ************************************************************
   // Low registers keep only their upper byte; their reserved bits take no flop
   logic [15:0] ch5_gain_word_high_reg;
   logic [7:0]  ch5_gain_word_low_reg;
   logic [15:0] ch6_config_reg;
   logic [15:0] ch6_offset_word_high_reg;
   logic [7:0]  ch6_offset_word_low_reg;
   logic [15:0] ch6_gain_word_high_reg;
   logic [31:0] rd_next;
   logic        hit;
   logic        req;
   logic        wr_en;
   logic        full_word;
   logic [7:0]  idx;
   logic        rd_req;
   // Bookkeeping for the checks: which kind of read was last taken
   logic        rd_taken;
   logic        rd_low_taken;
   logic        rd_cfg_taken;
   logic        rd_miss_taken;

   // ************************************************************
   // Bus decode
   // ************************************************************
   // Request seen and not yet answered; ack drops the cycle after
   assign req       = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
   assign idx       = wb_req_i.adr[ADDR_W-1:2];
   // Partial writes would tear a 16-bit word, so they are dropped
   assign full_word = (wb_req_i.sel[1:0] == 2'h3);
   assign wr_en     = req && wb_req_i.we && full_word && hit;
   // A read is taken at the same edge as a write would be; the data is
   // registered with the ack, so it stands exactly in the ack cycle
   assign rd_req    = req && !wb_req_i.we;

   // Read mux with hit detection; unmapped reads return zero with ack
   always_comb begin
      rd_next = 32'h0000_0000;
      hit     = 1'b1;
      if (idx == IDX_CH5_GAIN_CAL_HIGH) begin
         rd_next[15:0] = ch5_gain_word_high_reg;
      end else if (idx == IDX_CH5_GAIN_CAL_LOW) begin
         rd_next[15:0] = {ch5_gain_word_low_reg, 8'h00};
      end else if (idx == IDX_CH6_CONFIG) begin
         rd_next[15:0] = ch6_config_reg & CONFIG_WRITE_MASK;
      end else if (idx == IDX_CH6_OFFSET_CAL_HIGH) begin
         rd_next[15:0] = ch6_offset_word_high_reg;
      end else if (idx == IDX_CH6_OFFSET_CAL_LOW) begin
         rd_next[15:0] = {ch6_offset_word_low_reg, 8'h00};
      end else if (idx == IDX_CH6_GAIN_CAL_HIGH) begin
         rd_next[15:0] = ch6_gain_word_high_reg;
      end else begin
         hit = 1'b0;
      end
   end

   // Trade-off: a registered ack costs a wait state but keeps outputs flops
   // Ack and read data, registered; every request is acknowledged
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_req_i.we) begin
            wb_dat_o <= rd_next;
         end
      end
   end

   // ************************************************************
   // Channel 5 gain pair
   // ************************************************************
   // High and low update independently; no pairing between the halves
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ch5_gain_word_high_reg <= RST_GAIN_HIGH;
         ch5_gain_word_low_reg  <= RST_GAIN_LOW[15:8];
      end else if (wr_en) begin
         if (idx == IDX_CH5_GAIN_CAL_HIGH) begin
            ch5_gain_word_high_reg <= wb_req_i.dat[15:0];
         end else if (idx == IDX_CH5_GAIN_CAL_LOW) begin
            // Only the upper byte is stored; bits 7:0 are dropped
            ch5_gain_word_low_reg <= wb_req_i.dat[15:8];
         end
      end
   end

   // ************************************************************
   // Channel 6 configuration, offset pair and gain high
   // ************************************************************
   // Configuration, masked so a reserved bit can never read back as one
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ch6_config_reg <= RST_CONFIG;
      end else if (wr_en && idx == IDX_CH6_CONFIG) begin
         // Reserved bits 5:3 never store a one
         ch6_config_reg <= wb_req_i.dat[15:0] & CONFIG_WRITE_MASK;
      end
   end

   // Offset pair; a 24-bit update takes two writes and may tear between
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ch6_offset_word_high_reg <= RST_OFFSET_HIGH;
         ch6_offset_word_low_reg  <= RST_OFFSET_LOW[15:8];
      end else if (wr_en) begin
         if (idx == IDX_CH6_OFFSET_CAL_HIGH) begin
            ch6_offset_word_high_reg <= wb_req_i.dat[15:0];
         end else if (idx == IDX_CH6_OFFSET_CAL_LOW) begin
            ch6_offset_word_low_reg <= wb_req_i.dat[15:8];
         end
      end
   end

   // Gain high only; the matching low register belongs to another block
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ch6_gain_word_high_reg <= RST_GAIN_HIGH;
      end else if (wr_en && idx == IDX_CH6_GAIN_CAL_HIGH) begin
         ch6_gain_word_high_reg <= wb_req_i.dat[15:0];
      end
   end

   // ************************************************************
   // Datapath outputs, registered one cycle behind the storage
   // ************************************************************
   // The gain low for channel 6 lives elsewhere, so only the high part
   // is offered; gains are unsigned codes, the offset two's complement.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ch5_gain_o         <= {RST_GAIN_HIGH, RST_GAIN_LOW[15:8]};
         ch6_gain_high_o    <= {RST_GAIN_HIGH, 8'h00};
         ch6_offset_o       <= {RST_OFFSET_HIGH, RST_OFFSET_LOW[15:8]};
         ch6_config_o       <= '0;
         ch6_dc_filter_on_o <= 1'b0;
      end else begin
         // Unsigned 24-bit gain, 800000h means unity
         ch5_gain_o      <= {ch5_gain_word_high_reg, ch5_gain_word_low_reg};
         ch6_gain_high_o <= {ch6_gain_word_high_reg, 8'h00};
         ch6_offset_o    <= {ch6_offset_word_high_reg,
                             ch6_offset_word_low_reg};
         ch6_config_o.phase_delay <=
            ch6_config_reg[15:PHASE_LSB];
         ch6_config_o.dc_filter_off <= ch6_config_reg[DC_OFF_BIT];
         ch6_config_o.input_select  <= input_select_type'(
            ch6_config_reg[INPUT_SEL_LSB +: 2]);
         // Per-channel disable overrides the global setting
         ch6_dc_filter_on_o <= !ch6_config_reg[DC_OFF_BIT] &&
                               global_dc_filter_setting_i;
      end
   end

   // ************************************************************
   // Read tracking for the checks
   // ************************************************************
   // Remembers what kind of read was taken at the last edge, so that
   // the checks can look at the data in the ack cycle. Bookkeeping
   // only: nothing here feeds the bus or the datapath outputs.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_taken      <= 1'b0;
         rd_low_taken  <= 1'b0;
         rd_cfg_taken  <= 1'b0;
         rd_miss_taken <= 1'b0;
      end else begin
         rd_taken      <= rd_req;
         rd_low_taken  <= rd_req && (idx == IDX_CH5_GAIN_CAL_LOW ||
                          idx == IDX_CH6_OFFSET_CAL_LOW);
         rd_cfg_taken  <= rd_req && idx == IDX_CH6_CONFIG;
         rd_miss_taken <= rd_req && !hit;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   // All checks are off while reset is held; the datapath words lag the
   // storage by one edge, so write-through checks look two edges ahead.

   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_follows_req: assert property (req |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   a_low_reserved_zero: assert property (
      rd_low_taken |-> wb_dat_o[7:0] == 8'h00)
      else $error("reserved low byte read nonzero");
   a_cfg_reserved_zero: assert property (
      ch6_config_reg[5:3] == 3'h0)
      else $error("config reserved bits set");
   a_gain_write_seen: assert property (
      wr_en && idx == IDX_CH5_GAIN_CAL_HIGH |=> ##1
      ch5_gain_o[23:8] == $past(wb_req_i.dat[15:0], 2))
      else $error("gain high not reflected in gain word");
   a_offset_write_seen: assert property (
      wr_en && idx == IDX_CH6_OFFSET_CAL_LOW |=> ##1
      ch6_offset_o[7:0] == $past(wb_req_i.dat[15:8], 2))
      else $error("offset low not reflected in offset word");
   a_phase_write_seen: assert property (
      wr_en && idx == IDX_CH6_CONFIG |=> ##1
      ch6_config_o.phase_delay == $past(wb_req_i.dat[15:6], 2))
      else $error("phase delay not reflected");
   a_dc_disable: assert property (
      ch6_config_reg[DC_OFF_BIT] |=> !ch6_dc_filter_on_o)
      else $error("dc filter on while disabled");
   a_select_follows: assert property (
      ##1 ch6_config_o.input_select == $past(ch6_config_reg[1:0]))
      else $error("input select mismatch");
   a_partial_ignored: assert property (
      req && wb_req_i.we && !full_word |=> $stable(ch6_config_reg) &&
      $stable(ch5_gain_word_high_reg))
      else $error("partial write altered a register");
   // Bus handshake and read data
   a_ack_answers_req: assert property (
      wb_ack_o |-> $past(req))
      else $error("ack without a request");
   a_rdata_holds: assert property (
      !rd_taken |-> $stable(wb_dat_o))
      else $error("read data changed without a read");
   a_upper_half_zero: assert property (
      wb_dat_o[31:16] == 16'h0000)
      else $error("read data upper half nonzero");
   a_unmapped_zero: assert property (
      rd_miss_taken |-> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read returned data");
   a_cfg_read_reserved: assert property (
      rd_cfg_taken |-> wb_dat_o[5:3] == 3'h0)
      else $error("config reserved bits read nonzero");
   // Reads and refused writes must leave every register alone
   a_read_no_change: assert property (
      rd_req |=> $stable(ch6_config_reg) &&
      $stable(ch6_offset_word_high_reg) && $stable(ch5_gain_word_low_reg))
      else $error("read altered a register");
   a_miss_write_ignored: assert property (
      req && wb_req_i.we && !hit |=> $stable(ch6_config_reg) &&
      $stable(ch6_gain_word_high_reg) && $stable(ch6_offset_word_low_reg))
      else $error("unmapped write altered a register");

   // Stored fields and their datapath views
   a_gain_high_stored: assert property (
      wr_en && idx == IDX_CH5_GAIN_CAL_HIGH |=>
      ch5_gain_word_high_reg == $past(wb_req_i.dat[15:0]))
      else $error("gain high not stored");
   a_low_byte_stored: assert property (
      wr_en && idx == IDX_CH5_GAIN_CAL_LOW |=>
      ch5_gain_word_low_reg == $past(wb_req_i.dat[15:8]))
      else $error("gain low byte not stored");
   a_offset_high_stored: assert property (
      wr_en && idx == IDX_CH6_OFFSET_CAL_HIGH |=>
      ch6_offset_word_high_reg == $past(wb_req_i.dat[15:0]))
      else $error("offset high not stored");
   a_offset_low_stored: assert property (
      wr_en && idx == IDX_CH6_OFFSET_CAL_LOW |=>
      ch6_offset_word_low_reg == $past(wb_req_i.dat[15:8]))
      else $error("offset low byte not stored");
   a_phase_stored: assert property (
      wr_en && idx == IDX_CH6_CONFIG |=>
      ch6_config_reg[15:PHASE_LSB] == $past(wb_req_i.dat[15:6]))
      else $error("phase delay not stored");
   a_select_stored: assert property (
      wr_en && idx == IDX_CH6_CONFIG |=>
      ch6_config_reg[1:0] == $past(wb_req_i.dat[1:0]))
      else $error("input select not stored");
   a_gain_low_seen: assert property (
      wr_en && idx == IDX_CH5_GAIN_CAL_LOW |=> ##1
      ch5_gain_o[7:0] == $past(wb_req_i.dat[15:8], 2))
      else $error("gain low not reflected in gain word");
   a_ch6_gain_seen: assert property (
      wr_en && idx == IDX_CH6_GAIN_CAL_HIGH |=> ##1
      ch6_gain_high_o[23:8] == $past(wb_req_i.dat[15:0], 2))
      else $error("ch6 gain high not reflected");
   a_offset_high_seen: assert property (
      wr_en && idx == IDX_CH6_OFFSET_CAL_HIGH |=> ##1
      ch6_offset_o[23:8] == $past(wb_req_i.dat[15:0], 2))
      else $error("offset high not reflected in offset word");
   // The channel 6 gain low byte lives outside this bank
   a_ch6_gain_low_zero: assert property (
      ch6_gain_high_o[7:0] == 8'h00)
      else $error("ch6 gain low byte nonzero");

   // DC filter control
   a_dc_follows_global: assert property (
      !ch6_config_reg[DC_OFF_BIT] |=>
      ch6_dc_filter_on_o == $past(global_dc_filter_setting_i))
      else $error("dc filter ignores the global setting");
   a_dc_off_bit: assert property (
      ##1 ch6_config_o.dc_filter_off == $past(ch6_config_reg[DC_OFF_BIT]))
      else $error("dc filter disable bit mismatch");

   // Printed values stand at the first edge after reset is released
   a_reset_gain: assert property (
      $rose(arst_n_i) |-> ch5_gain_word_high_reg == RST_GAIN_HIGH &&
      ch5_gain_word_low_reg == RST_GAIN_LOW[15:8] &&
      ch6_gain_word_high_reg == RST_GAIN_HIGH)
      else $error("gain registers not at reset value");
   a_reset_clear: assert property (
      $rose(arst_n_i) |-> ch6_config_reg == RST_CONFIG &&
      ch6_offset_word_high_reg == RST_OFFSET_HIGH &&
      ch6_offset_word_low_reg == RST_OFFSET_LOW[15:8])
      else $error("offset or config not cleared by reset");

   // Main scenarios the bench is expected to reach
   c_write_cfg: cover property (wr_en && idx == IDX_CH6_CONFIG);
   c_read_gain: cover property (req && !wb_req_i.we &&
                                idx == IDX_CH5_GAIN_CAL_HIGH);
   c_unmapped: cover property (req && !hit);
   c_dc_off: cover property (ch6_config_o.dc_filter_off);
   c_partial_write: cover property (req && wb_req_i.we && !full_word);

endmodule : cal_cfg_regs

// ---- dv/cal_cfg_regs_test.sv ----
// Self-checking bench for the channel calibration register bank.
// Assumes the bank answers classic Wishbone cycles on sys_clk_i and that
// this bench alone drives every input of the bank.
`timescale 1ns/100ps
module cal_cfg_regs_test;
   import cal_cfg_pkg::*;

   // ************************************************************
   // Signals, register model and design instance
   // ************************************************************
   localparam logic [7:0]  IDX_TAB [6] = '{8'h25, 8'h26, 8'h27, 8'h28,
                                           8'h29, 8'h2A};
   localparam logic [15:0] MASK    [6] = '{16'hFFFF, 16'hFF00, 16'hFFC7,
                                           16'hFFFF, 16'hFF00, 16'hFFFF};
   localparam logic [15:0] RST_TAB [6] = '{16'h8000, 16'h0000, 16'h0000,
                                           16'h0000, 16'h0000, 16'h8000};
   logic               sys_clk_i = 1'b0;
   logic               arst_n_i  = 1'b0;
   wb_req_type         req       = '0;
   logic               glob_dc   = 1'b0;
   logic [31:0]        wb_dat_o;
   logic               wb_ack_o;
   logic [23:0]        ch5_gain_o;
   logic [23:0]        ch6_gain_high_o;
   logic signed [23:0] ch6_offset_o;
   ch_config_type      ch6_config_o;
   logic               ch6_dc_filter_on_o;
   logic [15:0]        model [6];
   logic [31:0]        rd;
   int                 n_errors  = 0;
   int                 n_tests   = 0;

   // Free-running 200 MHz clock
   always #2.5 sys_clk_i = ~sys_clk_i;

   cal_cfg_regs cal_cfg_regs_i (
      .sys_clk_i                  (sys_clk_i),
      .arst_n_i                   (arst_n_i),
      .wb_req_i                   (req),
      .global_dc_filter_setting_i (glob_dc),
      .wb_dat_o                   (wb_dat_o),
      .wb_ack_o                   (wb_ack_o),
      .ch5_gain_o                 (ch5_gain_o),
      .ch6_gain_high_o            (ch6_gain_high_o),
      .ch6_offset_o               (ch6_offset_o),
      .ch6_config_o               (ch6_config_o),
      .ch6_dc_filter_on_o         (ch6_dc_filter_on_o)
   );

   // ************************************************************
   // Tasks
   // ************************************************************
   // Case inequality so an unknown never passes as a match
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic final_report;
      $display("Checks made %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report

   // One classic cycle; values read right after the edge are the sampled
   // ones, since the bank updates its outputs by non-blocking assignment
   task automatic wb_cycle(input logic we_v, input logic [7:0] idx,
                           input logic [31:0] wd, input logic [3:0] sel_v);
      int n;
      n = 0;
      req <= '{cyc: 1'b1, stb: 1'b1, we: we_v, sel: sel_v,
               adr: {idx, 2'b00}, dat: wd};
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      req <= '0;
      if (wb_ack_o !== 1'b1) begin
         check("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
         final_report();
      end
      // Idle cycle so the next request starts from a dropped strobe
      @(posedge sys_clk_i);
   endtask : wb_cycle

   // Write that also updates the model when both low lanes are enabled
   task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
      wb_cycle(1'b1, IDX_TAB[i], d, s);
      if (s[1:0] == 2'b11) model[i] = d[15:0] & MASK[i];
   endtask : wr

   task automatic check_all;
      for (int i = 0; i < 6; i++) begin
         wb_cycle(1'b0, IDX_TAB[i], 32'h0, 4'hF);
         check($sformatf("reg %0d", i), {16'h0, model[i]}, rd);
      end
      check("ch5_gain", {8'h0, model[0], model[1][15:8]},
            {8'h0, ch5_gain_o});
      check("ch6_gain", {8'h0, model[5], 8'h00},
            {8'h0, ch6_gain_high_o});
      check("ch6_offset", {8'h0, model[3], model[4][15:8]},
            {8'h0, ch6_offset_o});
      check("ch6_config", {19'h0, model[2][15:6], model[2][2:0]},
            {19'h0, ch6_config_o});
      check("dc_on", {31'h0, glob_dc & ~model[2][2]},
            {31'h0, ch6_dc_filter_on_o});
   endtask : check_all

   task automatic do_reset;
      arst_n_i <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      model = RST_TAB;
      @(posedge sys_clk_i);
   endtask : do_reset

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      void'($urandom(32'hF7F76588));
      do_reset();
      check_all();
      // Random whole-word writes, including junk in reserved bits
      repeat (4) begin
         for (int i = 0; i < 6; i++) wr(i, $urandom(), 4'hF);
         glob_dc <= 1'($urandom());
         check_all();
      end
      // Every input selection with the filter bit both ways
      for (int s = 0; s < 8; s++) begin
         glob_dc <= ~glob_dc;
         wr(2, ($urandom() & 32'hFFFFFFF8) | s, 4'hF);
         check_all();
      end
      // Partial lanes and unmapped addresses are acked but change nothing
      wr(3, $urandom(), 4'b0001);
      wr(5, $urandom(), 4'b1110);
      wb_cycle(1'b1, 8'h24, $urandom(), 4'hF);
      wb_cycle(1'b1, 8'h2B, $urandom(), 4'hF);
      wb_cycle(1'b0, 8'h2B, 32'h0, 4'hF);
      check("unmapped read", 32'h0, rd);
      check_all();
      // Second reset in mid-run must restore every printed value
      do_reset();
      check_all();
      final_report();
   end
endmodule : cal_cfg_regs_test
